/* rtl/wdg_pkg.sv */
// shared types of the watchdog block
package wdg_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wdg_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } wdg_apb_rsp_s;

    typedef enum logic [1:0] {
        WDG_STOPPED,
        WDG_IRQ_ONLY,
        WDG_RST_ONLY,
        WDG_IRQ_THEN_RST
    } wdg_mode_e;

endpackage : wdg_pkg

/* rtl/wdg_regs.svh */
// register offsets, field positions and timing figures of the watchdog block
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_ADDR_W          12
`define WDG_CAUSE_IDX       12'h055
`define WDG_CTRL_IDX        12'h060
`define WDG_IDX_SHIFT       2

`define WDG_CAUSE_POR       0
`define WDG_CAUSE_PIN       1
`define WDG_CAUSE_BOD       2
`define WDG_CAUSE_DOG       3
`define WDG_CAUSE_USED      4'hF

`define WDG_CTRL_TSEL_LO    0
`define WDG_CTRL_RST_EN     3
`define WDG_CTRL_UNLOCK     4
`define WDG_CTRL_TSEL_HI    5
`define WDG_CTRL_IRQ_EN     6
`define WDG_CTRL_IRQ_FLAG   7

`define WDG_BASE_CYCLES     2048
`define WDG_TSEL_MAX        4'h9
`define WDG_OSC_HZ          128000
`define WDG_SYS_HZ          50000000
`define WDG_UNLOCK_CYCLES   4
`define WDG_CNT_W           21
`define WDG_CAUSE_POR_VAL   4'h1

`endif

/* rtl/wdg_timeout_counter.sv */
// oscillator-cycle counter that fires one pulse at the selected timeout
`timescale 1ns/1ns
`default_nettype none
`include "wdg_regs.svh"

module wdg_timeout_counter #(
    parameter int BASE_CYCLES = `WDG_BASE_CYCLES,
    parameter int CNT_W       = `WDG_CNT_W
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic       osc_i,
    input  wire logic       run_i,
    input  wire logic       restart_i,
    input  wire logic [3:0] tsel_i,
    output logic            timeout_o
);
    logic             osc_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             timeout_reg;
    logic             timeout_next;
    wire              osc_tick;
    wire  [3:0]       tsel_eff;
    wire  [CNT_W-1:0] limit;
    wire              at_limit;

    if (BASE_CYCLES < 1 || (BASE_CYCLES << 9) > (1 << CNT_W)) begin : g_chk
        $error("wdg_timeout_counter: BASE_CYCLES does not fit CNT_W");
    end

    // ----------------------------------------------------------------
    // period selection
    // ----------------------------------------------------------------
    // reserved codes fall back
    assign tsel_eff = (tsel_i > `WDG_TSEL_MAX) ? `WDG_TSEL_MAX : tsel_i;
    assign limit    = CNT_W'(BASE_CYCLES) << tsel_eff;
    // one step per oscillator rising edge
    assign osc_tick = osc_i & ~osc_reg;
    assign at_limit = (count_reg == limit - CNT_W'(1));

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    always_comb begin
        count_next   = count_reg;
        timeout_next = 1'b0;
        if (!run_i || restart_i) begin
            count_next = '0;
        end else if (osc_tick) begin
            if (at_limit) begin
                count_next   = '0;
                timeout_next = 1'b1;
            end else begin
                count_next = count_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            osc_reg     <= 1'b0;
            count_reg   <= '0;
            timeout_reg <= 1'b0;
        end else begin
            osc_reg     <= osc_i;
            count_reg   <= count_next;
            timeout_reg <= timeout_next;
        end
    end

    assign timeout_o = timeout_reg;

endmodule : wdg_timeout_counter
`default_nettype wire

/* rtl/wdg_top.sv */
// watchdog with control register, reset-cause register and APB slave
`timescale 1ns/1ns
`default_nettype none
`include "wdg_regs.svh"

// Contract
// - reset-cause bits 7..4 always read zero
// - watchdog cause set on watchdog reset, cleared by power-on or write zero
// - brown-out cause set on brown-out, cleared by power-on or write zero
// - pin cause set on pin reset, cleared by power-on or write zero
// - power-on cause set on power-on, cleared only by writing zero
// - timeout in interrupt operation sets the interrupt flag
// - flag cleared by vector execution or by writing one
// - interrupt requested only with global enable, local enable and flag
// - in combined mode vector clears enable and flag, leaving reset mode
// - combined mode: first timeout flags, unserviced second timeout resets
// - reset and interrupt enables select stopped, irq, reset or both
// - force-on setting at zero forces reset mode
// - clearing reset enable or changing period needs unlock set
// - unlock bit clears itself four clock cycles after set
// - reset enable reads set and stays set while watchdog cause set
// - four-bit period field at bits 5,2..0, 2048 cycles doubling to code 9
// - counter advances on the slow on-chip oscillator
// - reset-mode timeout gives a one-cycle internal reset pulse
// - restart instruction clears the count to zero
module wdg_top
    import wdg_pkg::*;
#(
    parameter int BASE_CYCLES   = `WDG_BASE_CYCLES,
    parameter int UNLOCK_CYCLES = `WDG_UNLOCK_CYCLES
) (
    input  wire logic                clk_sys_i,
    input  wire logic                reset_n_i,
    input  wire wdg_pkg::wdg_apb_req_s apb_req_i,
    output wdg_pkg::wdg_apb_rsp_s    apb_rsp_o,
    input  wire logic                osc_128k_i,
    input  wire logic                dog_restart_i,
    input  wire logic                irq_vector_taken_i,
    input  wire logic                global_irq_enable_i,
    input  wire logic                force_on_setting_i,
    input  wire logic                power_on_event_i,
    input  wire logic                brownout_event_i,
    input  wire logic                pin_reset_event_i,
    output logic                     dog_irq_o,
    output logic                     dog_reset_o
);
    import wdg_pkg::*;

    localparam int UNLOCK_W = $clog2(UNLOCK_CYCLES + 1);

    if (UNLOCK_CYCLES < 1) begin : g_chk
        $error("wdg_top: UNLOCK_CYCLES must be at least one");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0]          cause_reg;
    logic [3:0]          cause_next;
    logic                irq_flag_reg;
    logic                irq_flag_next;
    logic                irq_en_reg;
    logic                irq_en_next;
    logic                rst_en_reg;
    logic                rst_en_next;
    logic [3:0]          tsel_reg;
    logic [3:0]          tsel_next;
    logic [UNLOCK_W-1:0] unlock_cnt_reg;
    logic [UNLOCK_W-1:0] unlock_cnt_next;
    logic                dog_reset_reg;
    logic                dog_reset_next;
    logic [7:0]          rdata_reg;
    logic [7:0]          rdata_next;
    logic                err_reg;
    logic                timeout;
    wdg_mode_e           mode;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire [11:0] cause_addr = 12'(`WDG_CAUSE_IDX << `WDG_IDX_SHIFT);
    wire [11:0] ctrl_addr  = 12'(`WDG_CTRL_IDX << `WDG_IDX_SHIFT);
    wire        setup_ph   = apb_req_i.psel & ~apb_req_i.penable;
    wire        access_ph  = apb_req_i.psel & apb_req_i.penable;
    wire        hit_cause  = (apb_req_i.paddr == cause_addr);
    wire        hit_ctrl   = (apb_req_i.paddr == ctrl_addr);
    wire        hit_none   = ~hit_cause & ~hit_ctrl;
    wire        wr_cause   = access_ph & apb_req_i.pwrite & hit_cause;
    wire        wr_ctrl    = access_ph & apb_req_i.pwrite & hit_ctrl;
    wire [7:0]  wd         = apb_req_i.pwdata[7:0];

    // ----------------------------------------------------------------
    // derived control
    // ----------------------------------------------------------------
    wire unlocked   = (unlock_cnt_reg != '0);
    wire dog_cause  = cause_reg[`WDG_CAUSE_DOG];
    wire forced     = ~force_on_setting_i;
    wire rst_en_eff = forced | rst_en_reg | dog_cause;
    wire irq_en_eff = ~forced & irq_en_reg;
    wire [3:0] tsel_wr = {wd[`WDG_CTRL_TSEL_HI], wd[`WDG_CTRL_TSEL_LO +: 3]};

    assign mode = wdg_mode_e'({rst_en_eff, irq_en_eff});

    wire [7:0] ctrl_view = {irq_flag_reg, irq_en_eff, tsel_reg[3], unlocked,
                            rst_en_eff, tsel_reg[2:0]};
    wire [7:0] cause_view = {4'h0, cause_reg};

    // ----------------------------------------------------------------
    // timeout counter on the slow oscillator
    // ----------------------------------------------------------------
    // counter runs on oscillator edges
    wdg_timeout_counter #(
        .BASE_CYCLES (BASE_CYCLES),
        .CNT_W       (`WDG_CNT_W)
    ) u_counter (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .osc_i     (osc_128k_i),
        .run_i     (mode != WDG_STOPPED),
        .restart_i (dog_restart_i),
        .tsel_i    (tsel_reg),
        .timeout_o (timeout)
    );

    // ----------------------------------------------------------------
    // timeout action and interrupt flag
    // ----------------------------------------------------------------
    always_comb begin
        dog_reset_next = 1'b0;
        irq_flag_next  = irq_flag_reg;
        irq_en_next    = irq_en_reg;
        if (wr_ctrl && wd[`WDG_CTRL_IRQ_FLAG]) begin
            irq_flag_next = 1'b0;
        end
        if (wr_ctrl) begin
            irq_en_next = wd[`WDG_CTRL_IRQ_EN];
        end
        if (irq_vector_taken_i) begin
            irq_flag_next = 1'b0;
            // combined mode drops to reset only
            if (mode == WDG_IRQ_THEN_RST) begin
                irq_en_next = 1'b0;
            end
        end
        if (timeout) begin
            case (mode)
                WDG_IRQ_ONLY: begin
                    irq_flag_next = 1'b1;
                end
                WDG_RST_ONLY: begin
                    dog_reset_next = 1'b1;
                end
                // flag first, reset if still pending
                WDG_IRQ_THEN_RST: begin
                    if (irq_flag_reg) begin
                        dog_reset_next = 1'b1;
                    end else begin
                        irq_flag_next = 1'b1;
                    end
                end
                default: begin
                    dog_reset_next = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // protected configuration
    // ----------------------------------------------------------------
    always_comb begin
        rst_en_next     = rst_en_reg;
        tsel_next       = tsel_reg;
        unlock_cnt_next = unlocked ? unlock_cnt_reg - UNLOCK_W'(1) : unlock_cnt_reg;
        if (wr_ctrl) begin
            // setting the enable is always allowed
            if (wd[`WDG_CTRL_RST_EN]) begin
                rst_en_next = 1'b1;
            end else if (unlocked && !dog_cause) begin
                rst_en_next = 1'b0;
            end
            if (unlocked) begin
                tsel_next = tsel_wr;
            end
            if (wd[`WDG_CTRL_UNLOCK] && wd[`WDG_CTRL_RST_EN]) begin
                unlock_cnt_next = UNLOCK_W'(UNLOCK_CYCLES);
            end
        end
    end

    // ----------------------------------------------------------------
    // reset causes; a hardware set wins over a software clear
    // ----------------------------------------------------------------
    always_comb begin
        cause_next = cause_reg;
        // only a zero write clears a cause
        if (wr_cause) begin
            cause_next = cause_reg & wd[3:0];
        end
        if (dog_reset_reg) begin
            cause_next[`WDG_CAUSE_DOG] = 1'b1;
        end
        if (brownout_event_i) begin
            cause_next[`WDG_CAUSE_BOD] = 1'b1;
        end
        if (pin_reset_event_i) begin
            cause_next[`WDG_CAUSE_PIN] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    assign rdata_next = !setup_ph || apb_req_i.pwrite ? rdata_reg :
                        hit_cause ? cause_view :
                        hit_ctrl  ? ctrl_view  : 8'h00;

    // cause register survives system reset; only power-on resets it
    always_ff @(posedge clk_sys_i) begin
        if (power_on_event_i) begin
            cause_reg <= `WDG_CAUSE_POR_VAL;
        end else begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            irq_flag_reg   <= 1'b0;
            irq_en_reg     <= 1'b0;
            rst_en_reg     <= dog_cause;
            tsel_reg       <= 4'h0;
            unlock_cnt_reg <= '0;
            dog_reset_reg  <= 1'b0;
            rdata_reg      <= 8'h00;
            err_reg        <= 1'b0;
        end else begin
            irq_flag_reg   <= irq_flag_next;
            irq_en_reg     <= irq_en_next;
            rst_en_reg     <= rst_en_next;
            tsel_reg       <= tsel_next;
            unlock_cnt_reg <= unlock_cnt_next;
            dog_reset_reg  <= dog_reset_next;
            rdata_reg      <= rdata_next;
            err_reg        <= setup_ph ? hit_none : err_reg;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero-wait slave: every access completes in its first access cycle
    assign apb_rsp_o.pready  = 1'b1;
    assign apb_rsp_o.pslverr = access_ph & err_reg;
    assign apb_rsp_o.prdata  = {24'h000000, rdata_reg};

    // global enable, local enable and flag together
    assign dog_irq_o   = global_irq_enable_i & irq_en_eff & irq_flag_reg;
    assign dog_reset_o = dog_reset_reg;

endmodule : wdg_top
`default_nettype wire

/* testbench/tb_wdg_top.sv */
// self-checking bench of the watchdog block
`timescale 1ns/1ns
`default_nettype none
module tb_wdg_top;
    import wdg_pkg::*;
    localparam logic [11:0] CAUSE = 12'h154;
    localparam logic [11:0] CTRL  = 12'h180;
    logic clk_sys_i, reset_n_i, osc, osc_en, restart, vec, gie, force_on, por, bor, pin, irq, rst;
    wdg_apb_req_s req;
    wdg_apb_rsp_s rsp;
    int miscompares, check_count;

    wdg_top #(.BASE_CYCLES(4)) u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .osc_128k_i(osc), .dog_restart_i(restart), .irq_vector_taken_i(vec),
        .global_irq_enable_i(gie), .force_on_setting_i(force_on), .power_on_event_i(por),
        .brownout_event_i(bor), .pin_reset_event_i(pin), .dog_irq_o(irq), .dog_reset_o(rst));

    // ------------------------------------------------------------
    // clock, oscillator and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // slow clock only moves when a scenario lets it, so counts are predictable
    always @(posedge clk_sys_i) if (osc_en) osc <= ~osc;

    task automatic results();
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
        int n;
        @(posedge clk_sys_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            results();
        end
        q = {rsp.pslverr, rsp.prdata};
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        logic [32:0] q;
        apb(1'b0, a, 32'h0, q);
        cmp(q[31:0], exp[31:0]);
        cmp({31'h0, q[32]}, {31'h0, exp[32]});
    endtask : rd

    // waits for the interrupt (0) or the reset pulse (1)
    task automatic wait_hi(input logic which, input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
            if (n > lim) begin
                miscompares++;
                results();
            end
        end while ((which ? rst : irq) !== 1'b1);
    endtask : wait_hi

    task automatic do_reset(input logic p);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        por <= p;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        por <= 1'b0;
    endtask : do_reset

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_cause();
        rd(CAUSE, 33'h1);
        @(posedge clk_sys_i);
        bor <= 1'b1;
        pin <= 1'b1;
        @(posedge clk_sys_i);
        bor <= 1'b0;
        pin <= 1'b0;
        rd(CAUSE, 33'h7);
        wr(CAUSE, 32'hFFFF_FFF6);
        rd(CAUSE, 33'h6);
        do_reset(1'b0);
        rd(CAUSE, 33'h6);
        do_reset(1'b1);
        rd(CAUSE, 33'h1);
        rd(CTRL, 33'h0);
        wr(CAUSE, 32'h0);
        rd(CAUSE, 33'h0);
        rd(12'h000, 33'h1_0000_0000);
    endtask : t_cause

    // period per code, reserved code falls back to the longest
    task automatic t_periods();
        logic [3:0] codes[4] = '{4'h0, 4'h1, 4'h9, 4'hF};
        logic [31:0] v;
        int n, exp;
        foreach (codes[i]) begin
            v = {24'h0, 2'b01, codes[i][3], 2'b00, codes[i][2:0]};
            exp = 2 * (4 << ((codes[i] > 4'h9) ? 9 : codes[i]));
            restart <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            restart <= 1'b0;
            wr(CTRL, 32'h18);
            wr(CTRL, v);
            osc_en <= 1'b1;
            wait_hi(1'b0, exp + 20, n);
            @(posedge clk_sys_i) osc_en <= 1'b0;
            cmp(32'(n >= exp - 6 && n <= exp + 6), 32'h1);
            @(posedge clk_sys_i) gie <= 1'b0;
            @(negedge clk_sys_i) cmp({31'h0, irq}, 32'h0);
            @(posedge clk_sys_i) gie <= 1'b1;
            wr(CTRL, v | 32'h80);
            @(negedge clk_sys_i) cmp({31'h0, irq}, 32'h0);
        end
    endtask : t_periods

    task automatic t_combined();
        int n;
        @(posedge clk_sys_i) restart <= 1'b1;
        @(posedge clk_sys_i) restart <= 1'b0;
        // back to the shortest period, left at a reserved code before
        wr(CTRL, 32'h18);
        wr(CTRL, 32'h48);
        osc_en <= 1'b1;
        wait_hi(1'b0, 40, n);
        @(posedge clk_sys_i) vec <= 1'b1;
        @(posedge clk_sys_i) vec <= 1'b0;
        rd(CTRL, 33'h08);
        wait_hi(1'b1, 40, n);
        wr(CTRL, 32'h48);
        wait_hi(1'b0, 40, n);
        wait_hi(1'b1, 40, n);
        @(posedge clk_sys_i) osc_en <= 1'b0;
        rd(CAUSE, 33'h8);
        do_reset(1'b0);
        rd(CTRL, 33'h08);
        wr(CTRL, 32'h18);
        wr(CTRL, 32'h0);
        rd(CTRL, 33'h08);
        wr(CAUSE, 32'h0);
        wr(CTRL, 32'h18);
        rd(CTRL, 33'h18);
        wr(CTRL, 32'h18);
        wr(CTRL, 32'h0);
        rd(CTRL, 33'h0);
        wr(CTRL, 32'h08);
        wr(CTRL, 32'h07);
        rd(CTRL, 33'h08);
        wr(CTRL, 32'h18);
        repeat (5) @(posedge clk_sys_i);
        rd(CTRL, 33'h08);
        force_on <= 1'b0;
        rd(CTRL, 33'h08);
        osc_en <= 1'b1;
        wait_hi(1'b1, 40, n);
        @(posedge clk_sys_i) osc_en <= 1'b0;
        force_on <= 1'b1;
    endtask : t_combined

    initial begin
        req = '0;
        {osc, osc_en, restart, vec, bor, pin} = '0;
        {gie, force_on, por, reset_n_i} = 4'b1110;
        miscompares = 0;
        check_count = 0;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        por <= 1'b0;
        t_cause();
        t_periods();
        t_combined();
        results();
    end
endmodule : tb_wdg_top
`default_nettype wire

/* testbench/wdg_top_chk.sv */
// port-level checks of the watchdog block
`timescale 1ns/1ns
`default_nettype none
module wdg_top_chk
    import wdg_pkg::*;
#(
    parameter int BASE_CYCLES   = 2048,
    parameter int UNLOCK_CYCLES = 4
) (
    input wire logic                   clk_sys_i,
    input wire logic                   reset_n_i,
    input wire wdg_pkg::wdg_apb_req_s  apb_req_i,
    input wire wdg_pkg::wdg_apb_rsp_s  apb_rsp_o,
    input wire logic                   osc_128k_i,
    input wire logic                   dog_restart_i,
    input wire logic                   irq_vector_taken_i,
    input wire logic                   global_irq_enable_i,
    input wire logic                   force_on_setting_i,
    input wire logic                   power_on_event_i,
    input wire logic                   brownout_event_i,
    input wire logic                   pin_reset_event_i,
    input wire logic                   dog_irq_o,
    input wire logic                   dog_reset_o
);
    // ------------------------------------------------------------
    // decode of the bus
    // ------------------------------------------------------------
    wire logic acc    = apb_req_i.psel & apb_req_i.penable;
    wire logic rd_acc = acc & ~apb_req_i.pwrite;
    wire logic cause  = apb_req_i.paddr == 12'h154;
    wire logic ctrl   = apb_req_i.paddr == 12'h180;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_unlock_wr;
        acc && apb_req_i.pwrite && ctrl && apb_req_i.pwdata[4:3] == 2'b11;
    endsequence
    sequence s_late_ctrl_read;
        (!apb_req_i.psel) [*5] ##[1:8] (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite && ctrl) ##1 acc;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_reset_one_cycle: assert property (dog_reset_o |=> !dog_reset_o)
        else $error("watchdog reset pulse longer than one cycle");
    chk_irq_gate_global: assert property (dog_irq_o |-> global_irq_enable_i && force_on_setting_i)
        else $error("interrupt without global enable or in forced mode");
    chk_vector_drops_irq: assert property (dog_irq_o && irq_vector_taken_i |=> !dog_irq_o)
        else $error("interrupt still raised after vector");
    chk_restart_holds_off: assert property (dog_restart_i [*4] |-> !dog_reset_o)
        else $error("reset pulse while restart held");
    chk_cause_upper_zero: assert property (rd_acc && cause |-> apb_rsp_o.prdata[31:4] == 28'h0)
        else $error("unused cause bits read non-zero");
    chk_forced_ctrl_bits: assert property (rd_acc && ctrl && !force_on_setting_i && !$past(force_on_setting_i)
        |-> apb_rsp_o.prdata[3] && !apb_rsp_o.prdata[6])
        else $error("forced mode enable bits wrong");
    chk_unmapped_error: assert property (acc |-> apb_rsp_o.pslverr == !(cause || ctrl))
        else $error("slave error flag wrong");
    chk_unlock_expires: assert property (s_unlock_wr ##1 s_late_ctrl_read |-> !apb_rsp_o.prdata[4])
        else $error("unlock bit still set after its window");
endmodule : wdg_top_chk

bind wdg_top wdg_top_chk #(.BASE_CYCLES(BASE_CYCLES), .UNLOCK_CYCLES(UNLOCK_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
    .osc_128k_i(osc_128k_i), .dog_restart_i(dog_restart_i), .irq_vector_taken_i(irq_vector_taken_i),
    .global_irq_enable_i(global_irq_enable_i), .force_on_setting_i(force_on_setting_i),
    .power_on_event_i(power_on_event_i), .brownout_event_i(brownout_event_i),
    .pin_reset_event_i(pin_reset_event_i), .dog_irq_o(dog_irq_o), .dog_reset_o(dog_reset_o));
`default_nettype wire
